// ---- logic/sas_pkg.sv ----
// Constants, types and decode functions for the converter sequencer.
// ---------------------------------------------------------------------------
// Function
// - 10-bit successive approximation, single or scan modes.
// - Single mode start converts one selected channel.
// - Result goes to the converted channel's register.
// - Single end sets flag, interrupt if enabled.
// - Start reads 1 during conversion, then self-clears.
// - Scan starts at group's first channel, in order.
// - Scan stores each channel result when done.
// - Last channel sets flag, interrupt, restarts group.
// - Scan repeats while start is 1; software stops.
// - Start delay 6-9 slow, 4-5 fast states.
// - Sampling lasts 31 slow or 15 fast states.
// - First conversion 131-134 slow, 69-70 fast states.
// - Later scan conversions 128 slow, 66 fast states.
// - Trigger pin accepted only with trigger enable set.
// - Falling trigger edge sets start and converts.
// - Triggered conversion behaves like software start.
// - Mode bit 0 single; time bit 0 slow.
// - Channel field: one channel, or group from zero.
// ---------------------------------------------------------------------------
package sas_pkg;

  // Widths of the datapath and of the register port.
  localparam int RES_W = 10;
  localparam int NCH = 4;
  localparam int CH_W = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W = 8;

  // Register offsets; data registers follow at OFS_DATA0 plus channel.
  localparam logic [3:0] OFS_CSR = 4'h0;
  localparam logic [3:0] OFS_AUX = 4'h1;
  localparam logic [3:0] OFS_DATA0 = 4'h2;

  // Control and status register fields and reset value.
  localparam int CSR_FLAG = 7;
  localparam int CSR_IE = 6;
  localparam int CSR_START = 5;
  localparam int CSR_SCAN = 4;
  localparam int CSR_CKS = 3;
  localparam int CSR_CH_LSB = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // Auxiliary control register fields, stored bits and fixed ones.
  localparam int AUX_TRG = 7;
  localparam logic [7:0] AUX_RW_MASK = 8'h8D;
  localparam logic [7:0] AUX_ONES = 8'h72;
  localparam logic [7:0] AUX_RESET = 8'h00;

  // One state is one system clock period.
  localparam int CLK_NS = 10;
  localparam int STATE_NS = 10;

  // Converts a count of states to whole clock cycles, rounded up.
  function automatic int sas_cyc(input int states);
    return (states * STATE_NS + CLK_NS - 1) / CLK_NS;
  endfunction : sas_cyc

  // Timing figures in states; index S is slow, F is fast selection.
  localparam int DLY_MIN_S_ST = 6;
  localparam int DLY_MAX_S_ST = 9;
  localparam int DLY_MIN_F_ST = 4;
  localparam int DLY_MAX_F_ST = 5;
  localparam int SPL_S_ST = 31;
  localparam int SPL_F_ST = 15;
  localparam int TOT_MIN_S_ST = 131;
  localparam int TOT_MAX_S_ST = 134;
  localparam int TOT_MIN_F_ST = 69;
  localparam int TOT_MAX_F_ST = 70;
  localparam int SCAN_S_ST = 128;
  localparam int SCAN_F_ST = 66;
  localparam int BIT_S_ST = 9;
  localparam int BIT_F_ST = 5;

  // Timing figures in clock cycles.
  localparam int DLY_MIN_S = sas_cyc(DLY_MIN_S_ST);
  localparam int DLY_MIN_F = sas_cyc(DLY_MIN_F_ST);
  localparam int SPL_S = sas_cyc(SPL_S_ST);
  localparam int SPL_F = sas_cyc(SPL_F_ST);
  localparam int TOT_MIN_S = sas_cyc(TOT_MIN_S_ST);
  localparam int TOT_MAX_S = sas_cyc(TOT_MAX_S_ST);
  localparam int TOT_MIN_F = sas_cyc(TOT_MIN_F_ST);
  localparam int TOT_MAX_F = sas_cyc(TOT_MAX_F_ST);
  localparam int SCAN_S = sas_cyc(SCAN_S_ST);
  localparam int SCAN_F = sas_cyc(SCAN_F_ST);
  localparam int BIT_S = sas_cyc(BIT_S_ST);
  localparam int BIT_F = sas_cyc(BIT_F_ST);
  localparam int DLY_SPAN_S = sas_cyc(DLY_MAX_S_ST) - DLY_MIN_S;
  localparam int DLY_SPAN_F = sas_cyc(DLY_MAX_F_ST) - DLY_MIN_F;
  localparam int CONV_S = TOT_MAX_S - sas_cyc(DLY_MAX_S_ST) - SPL_S;
  localparam int CONV_F = TOT_MAX_F - sas_cyc(DLY_MAX_F_ST) - SPL_F;
  localparam int GAP_S = SCAN_S - SPL_S - CONV_S;
  localparam int GAP_F = SCAN_F - SPL_F - CONV_F;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DELAY = 5'h02,
    ST_SAMPLE = 5'h04,
    ST_CONV = 5'h08,
    ST_GAP = 5'h10
  } sas_state_t;

  // One request on the register port.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sas_bus_req_t;

  // First channel converted after a start or a group restart.
  function automatic logic [CH_W-1:0] sas_first_chan(input logic scan,
                                                     input logic [2:0] ch);
    return scan ? 2'h0 : ch[CH_W-1:0];
  endfunction : sas_first_chan

endpackage : sas_pkg

// ---- logic/sas_sar_core.sv ----
// Successive approximation engine that resolves one result bit per step.
`timescale 1ns/1ps
module sas_sar_core (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control from the sequencer.
  input wire logic start_in,
  input wire logic [sas_pkg::CNT_W-1:0] step_len_in,
  input wire logic comp_in,
  // Trial code and final result.
  output logic [sas_pkg::RES_W-1:0] trial_out,
  output logic [sas_pkg::RES_W-1:0] result_out,
  output logic done_out
);

  logic [sas_pkg::RES_W-1:0] trial_q;
  logic [sas_pkg::RES_W-1:0] mask_q;
  logic [sas_pkg::CNT_W-1:0] step_q;
  logic busy_q;
  logic decide;
  logic [sas_pkg::RES_W-1:0] kept;

  // A step ends when its counter runs out; the comparator then decides.
  assign decide = busy_q && (step_q == 8'h00);
  assign kept = comp_in ? trial_q : (trial_q & ~mask_q);
  assign result_out = kept;
  assign done_out = decide && mask_q[0];
  assign trial_out = trial_q;

  // Tries each bit from the top, keeping it while the input is not below.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trial_q <= 10'h000;
      mask_q <= 10'h000;
      step_q <= 8'h00;
      busy_q <= 1'b0;
    end else if (start_in) begin
      trial_q <= 10'h200;
      mask_q <= 10'h200;
      step_q <= step_len_in - 8'h01;
      busy_q <= 1'b1;
    end else if (decide) begin
      trial_q <= kept | (mask_q >> 1);
      mask_q <= mask_q >> 1;
      step_q <= step_len_in - 8'h01;
      busy_q <= !mask_q[0];
    end else if (busy_q) begin
      step_q <= step_q - 8'h01;
    end
  end

endmodule : sas_sar_core

// ---- logic/sas_sequencer.sv ----
// Top of the converter sequencer: registers, trigger, timing and storage.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module sas_sequencer (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port.
  input wire sas_pkg::sas_bus_req_t bus_in,
  output logic [sas_pkg::DATA_W-1:0] rdata_out,
  // External trigger pin, active low.
  input wire logic ext_trigger_pin_n_in,
  // Analog front end.
  input wire logic comp_in,
  output logic sample_out,
  output logic [sas_pkg::CH_W-1:0] chan_out,
  output logic [sas_pkg::RES_W-1:0] dac_out,
  // Conversion end interrupt request.
  output logic conv_end_irq_out
);

  // -------------------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------------------
  logic conv_end_flag_q;
  logic conv_end_flag_d;
  logic flag_seen_q;
  logic flag_seen_d;
  logic conv_end_irq_enable_q;
  logic conv_start_bit_q;
  logic conv_start_bit_d;
  logic scan_mode_q;
  logic conv_time_select_q;
  logic [2:0] chan_sel_q;
  logic ext_trigger_enable_q;
  logic [7:0] aux_store_q;
  logic [sas_pkg::RES_W-1:0] data_q [sas_pkg::NCH];
  logic [sas_pkg::DATA_W-1:0] rdata_q;
  logic irq_q;

  // -------------------------------------------------------------------------
  // Sequencer state
  // -------------------------------------------------------------------------
  sas_pkg::sas_state_t state_q;
  sas_pkg::sas_state_t state_d;
  logic [sas_pkg::CNT_W-1:0] cnt_q;
  logic [sas_pkg::CNT_W-1:0] cnt_d;
  logic [sas_pkg::CH_W-1:0] cur_ch_q;
  logic [sas_pkg::CH_W-1:0] cur_ch_d;
  logic [1:0] phase_q;
  logic sample_q;
  logic [2:0] trg_sync_q;
  logic trg_lvl_q;
  logic trg_lvl_prev_q;
  logic [2:0] comp_sync_q;
  logic comp_lvl_q;

  // -------------------------------------------------------------------------
  // Register port decode
  // -------------------------------------------------------------------------
  logic csr_wr;
  logic csr_rd;
  logic aux_wr;
  logic [7:0] csr_rd_val;
  logic [7:0] aux_rd_val;
  logic [sas_pkg::DATA_W-1:0] rd_mux;
  logic [3:0] data_idx;
  logic data_hit;

  assign csr_wr = bus_in.wr && (bus_in.addr == sas_pkg::OFS_CSR);
  assign csr_rd = bus_in.rd && (bus_in.addr == sas_pkg::OFS_CSR);
  assign aux_wr = bus_in.wr && (bus_in.addr == sas_pkg::OFS_AUX);
  assign data_idx = bus_in.addr - sas_pkg::OFS_DATA0;
  assign data_hit = (bus_in.addr >= sas_pkg::OFS_DATA0) &&
                    (data_idx < 4'(sas_pkg::NCH));
  assign csr_rd_val = {conv_end_flag_q, conv_end_irq_enable_q,
                       conv_start_bit_q, scan_mode_q, conv_time_select_q,
                       chan_sel_q};
  assign aux_rd_val = aux_store_q | sas_pkg::AUX_ONES;

  // Read data selection; unmapped offsets read as zero.
  assign rd_mux = csr_rd ? {8'h00, csr_rd_val} :
                  (bus_in.addr == sas_pkg::OFS_AUX) ? {8'h00, aux_rd_val} :
                  data_hit ? {6'h00, data_q[data_idx[sas_pkg::CH_W-1:0]]} :
                  16'h0000;

  // -------------------------------------------------------------------------
  // Timing selection
  // -------------------------------------------------------------------------
  logic fast;
  logic [sas_pkg::CNT_W-1:0] dly_load;
  logic [sas_pkg::CNT_W-1:0] spl_len;
  logic [sas_pkg::CNT_W-1:0] conv_len;
  logic [sas_pkg::CNT_W-1:0] gap_len;
  logic [sas_pkg::CNT_W-1:0] bit_len;
  logic [sas_pkg::CNT_W-1:0] core_go_cnt;

  // The time select bit picks the slow or the fast set of figures.
  assign fast = conv_time_select_q;
  // The write phase against the free divider stretches the start delay.
  assign dly_load = fast ?
    8'(sas_pkg::DLY_MIN_F - 2) + (8'(phase_q) & 8'(sas_pkg::DLY_SPAN_F)) :
    8'(sas_pkg::DLY_MIN_S - 2) + (8'(phase_q) & 8'(sas_pkg::DLY_SPAN_S));
  assign spl_len = fast ? 8'(sas_pkg::SPL_F) : 8'(sas_pkg::SPL_S);
  assign conv_len = fast ? 8'(sas_pkg::CONV_F) : 8'(sas_pkg::CONV_S);
  assign gap_len = fast ? 8'(sas_pkg::GAP_F) : 8'(sas_pkg::GAP_S);
  assign bit_len = fast ? 8'(sas_pkg::BIT_F) : 8'(sas_pkg::BIT_S);
  assign core_go_cnt = 8'(10) * bit_len;

  // -------------------------------------------------------------------------
  // Trigger and sequencing events
  // -------------------------------------------------------------------------
  logic trig_fall;
  logic trig_start;
  logic conv_end;
  logic grp_last;
  logic abort;
  logic core_go;
  logic core_done;
  logic [sas_pkg::RES_W-1:0] core_result;
  logic [sas_pkg::RES_W-1:0] core_trial;

  assign trig_fall = trg_lvl_prev_q && !trg_lvl_q;
  assign trig_start = trig_fall && ext_trigger_enable_q;
  // Leaving the start bit low stops any conversion in progress.
  assign abort = !conv_start_bit_q && (state_q != sas_pkg::ST_IDLE);
  assign conv_end = (state_q == sas_pkg::ST_CONV) && (cnt_q == 8'h00) &&
                    !abort;
  // The group ends at the coded channel in either mode.
  assign grp_last = (cur_ch_q == chan_sel_q[sas_pkg::CH_W-1:0]);
  // The engine starts so that its last decision falls on conv_end.
  assign core_go = ((state_q == sas_pkg::ST_SAMPLE) && (cnt_q == 8'h00) &&
                    (core_go_cnt == conv_len)) ||
                   ((state_q == sas_pkg::ST_CONV) && (cnt_q == core_go_cnt));

  // Software writes, trigger sets, single-mode end clears the start bit.
  assign conv_start_bit_d =
    trig_start ? 1'b1 :
    csr_wr ? bus_in.wdata[sas_pkg::CSR_START] :
    (conv_end && !scan_mode_q) ? 1'b0 :
    conv_start_bit_q;

  // The flag sets at group end; the set wins over a clear.
  assign conv_end_flag_d = (conv_end && grp_last) ||
    (conv_end_flag_q && !(csr_wr && !bus_in.wdata[sas_pkg::CSR_FLAG] &&
                          flag_seen_q));
  assign flag_seen_d = (conv_end && grp_last) ? 1'b0 :
                       (csr_wr && flag_seen_q) ? 1'b0 :
                       (csr_rd && conv_end_flag_q) ? 1'b1 : flag_seen_q;

  // Next state and counter of the sequencer.
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
    cur_ch_d = cur_ch_q;
    if (abort) begin
      state_d = sas_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sas_pkg::ST_IDLE: begin
          if (conv_start_bit_q) begin
            state_d = sas_pkg::ST_DELAY;
            cnt_d = dly_load;
            cur_ch_d = sas_pkg::sas_first_chan(scan_mode_q, chan_sel_q);
          end
        end
        sas_pkg::ST_DELAY: begin
          if (cnt_q == 8'h00) begin
            state_d = sas_pkg::ST_SAMPLE;
            cnt_d = spl_len - 8'h01;
          end
        end
        sas_pkg::ST_SAMPLE: begin
          if (cnt_q == 8'h00) begin
            state_d = sas_pkg::ST_CONV;
            cnt_d = conv_len - 8'h01;
          end
        end
        sas_pkg::ST_CONV: begin
          if (cnt_q == 8'h00) begin
            if (scan_mode_q) begin
              state_d = sas_pkg::ST_GAP;
              cnt_d = gap_len - 8'h01;
              cur_ch_d = grp_last ? 2'h0 : cur_ch_q + 2'h1;
            end else begin
              state_d = sas_pkg::ST_IDLE;
            end
          end
        end
        sas_pkg::ST_GAP: begin
          if (cnt_q == 8'h00) begin
            state_d = sas_pkg::ST_SAMPLE;
            cnt_d = spl_len - 8'h01;
          end
        end
        default: begin
          state_d = sas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Synchronisers for the trigger pin and the comparator
  // -------------------------------------------------------------------------
  // A level counts once the second and third stages agree.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trg_sync_q <= 3'h7;
      trg_lvl_q <= 1'b1;
      trg_lvl_prev_q <= 1'b1;
      comp_sync_q <= 3'h0;
      comp_lvl_q <= 1'b0;
    end else begin
      trg_sync_q <= {trg_sync_q[1:0], ext_trigger_pin_n_in};
      if (trg_sync_q[1] == trg_sync_q[2]) begin
        trg_lvl_q <= trg_sync_q[2];
      end
      trg_lvl_prev_q <= trg_lvl_q;
      comp_sync_q <= {comp_sync_q[1:0], comp_in};
      if (comp_sync_q[1] == comp_sync_q[2]) begin
        comp_lvl_q <= comp_sync_q[2];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  // Control fields written by software; status flags by hardware.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      conv_end_flag_q <= sas_pkg::CSR_RESET[sas_pkg::CSR_FLAG];
      flag_seen_q <= 1'b0;
      conv_end_irq_enable_q <= sas_pkg::CSR_RESET[sas_pkg::CSR_IE];
      conv_start_bit_q <= sas_pkg::CSR_RESET[sas_pkg::CSR_START];
      scan_mode_q <= sas_pkg::CSR_RESET[sas_pkg::CSR_SCAN];
      conv_time_select_q <= sas_pkg::CSR_RESET[sas_pkg::CSR_CKS];
      chan_sel_q <= sas_pkg::CSR_RESET[2:0];
      aux_store_q <= sas_pkg::AUX_RESET;
    end else begin
      conv_end_flag_q <= conv_end_flag_d;
      flag_seen_q <= flag_seen_d;
      conv_start_bit_q <= conv_start_bit_d;
      if (csr_wr) begin
        conv_end_irq_enable_q <= bus_in.wdata[sas_pkg::CSR_IE];
        scan_mode_q <= bus_in.wdata[sas_pkg::CSR_SCAN];
        conv_time_select_q <= bus_in.wdata[sas_pkg::CSR_CKS];
        chan_sel_q <= bus_in.wdata[sas_pkg::CSR_CH_LSB +: 3];
      end
      if (aux_wr) begin
        aux_store_q <= bus_in.wdata[7:0] & sas_pkg::AUX_RW_MASK;
      end
    end
  end

  assign ext_trigger_enable_q = aux_store_q[sas_pkg::AUX_TRG];

  // Each channel's data register loads at the end of its conversion.
  for (genvar g = 0; g < sas_pkg::NCH; g++) begin : g_data
    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        data_q[g] <= 10'h000;
      end else if (conv_end && (cur_ch_q == 2'(g))) begin
        data_q[g] <= core_result;
      end
    end
  end

  // Sequencer, divider phase, outputs and read data.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= sas_pkg::ST_IDLE;
      cnt_q <= 8'h00;
      cur_ch_q <= 2'h0;
      phase_q <= 2'h0;
      sample_q <= 1'b0;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cur_ch_q <= cur_ch_d;
      phase_q <= phase_q + 2'h1;
      sample_q <= (state_d == sas_pkg::ST_SAMPLE);
      rdata_q <= bus_in.rd ? rd_mux : 16'h0000;
      irq_q <= conv_end_flag_d && conv_end_irq_enable_q;
    end
  end

  sas_sar_core u_core (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .start_in(core_go),
    .step_len_in(bit_len),
    .comp_in(comp_lvl_q),
    .trial_out(core_trial),
    .result_out(core_result),
    .done_out(core_done)
  );

  assign rdata_out = rdata_q;
  assign sample_out = sample_q;
  assign chan_out = cur_ch_q;
  assign dac_out = core_trial;
  assign conv_end_irq_out = irq_q;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic [sas_pkg::CNT_W-1:0] len_q;
  logic [sas_pkg::CNT_W-1:0] spl_cnt_q;
  logic first_q;
  logic [sas_pkg::CNT_W-1:0] exp_min;
  logic [sas_pkg::CNT_W-1:0] exp_max;
  logic [sas_pkg::CNT_W-1:0] exp_scan;

  assign exp_min = fast ? 8'(sas_pkg::TOT_MIN_F) : 8'(sas_pkg::TOT_MIN_S);
  assign exp_max = fast ? 8'(sas_pkg::TOT_MAX_F) : 8'(sas_pkg::TOT_MAX_S);
  assign exp_scan = fast ? 8'(sas_pkg::SCAN_F) : 8'(sas_pkg::SCAN_S);

  // Cycle count of the running conversion and of the sampling window.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      len_q <= 8'h01;
      spl_cnt_q <= 8'h00;
      first_q <= 1'b0;
    end else begin
      len_q <= (state_q == sas_pkg::ST_IDLE) ? 8'h02 :
               conv_end ? 8'h01 : len_q + 8'h01;
      spl_cnt_q <= sample_q ? spl_cnt_q + 8'h01 : 8'h00;
      first_q <= (state_q == sas_pkg::ST_IDLE) ? 1'b1 :
                 conv_end ? 1'b0 : first_q;
    end
  end

  sequence s_back_to_idle;
    ##1 (!conv_start_bit_q && state_q == sas_pkg::ST_IDLE);
  endsequence

  sequence s_restart_group;
    ##1 (state_q == sas_pkg::ST_GAP && cur_ch_q == 2'h0);
  endsequence

  a_single_self_clear: assert property (
    conv_end && !scan_mode_q && !csr_wr && !trig_start |-> s_back_to_idle)
    else $error("start bit not cleared after single conversion");

  a_flag_at_end: assert property (
    conv_end && grp_last |=> conv_end_flag_q)
    else $error("end flag not set at group end");

  a_irq_gated: assert property (
    conv_end_irq_out == (conv_end_flag_q && $past(conv_end_irq_enable_q)))
    else $error("interrupt request does not follow flag and enable");

  a_result_stored: assert property (
    conv_end |=> data_q[$past(cur_ch_q)] == $past(core_result))
    else $error("result not stored in its channel register");

  a_engine_aligned: assert property (
    conv_end |-> core_done)
    else $error("engine decision not aligned with conversion end");

  a_first_length: assert property (
    conv_end && first_q |-> len_q >= exp_min && len_q <= exp_max)
    else $error("first conversion time out of range");

  a_scan_length: assert property (
    conv_end && !first_q |-> len_q == exp_scan)
    else $error("later scan conversion time wrong");

  a_sample_window: assert property (
    $fell(sample_q) && conv_start_bit_q |-> spl_cnt_q == spl_len)
    else $error("sampling window has wrong length");

  a_scan_restart: assert property (
    conv_end && scan_mode_q && grp_last && conv_start_bit_d
      |-> s_restart_group ##0 conv_start_bit_q)
    else $error("scan did not restart at first channel");

  a_trigger_gate: assert property (
    trig_fall && !csr_wr |=> conv_start_bit_q == ($past(conv_start_bit_q) ||
      $past(ext_trigger_enable_q)) || $past(conv_end))
    else $error("trigger pin handled against its enable");

endmodule : sas_sequencer

// ---- sim/sas_analog_model.sv ----
// Comparator model of the analog inputs behind a sample-and-hold.
`timescale 1ns/1ps
module sas_analog_model (
  // Mux and converter side.
  input wire logic sample_in,
  input wire logic [sas_pkg::CH_W-1:0] chan_in,
  input wire logic [sas_pkg::RES_W-1:0] dac_in,
  // Comparator decision.
  output logic comp_out
);
  // Fixed input levels per channel, as ideal codes; one at the top of the range.
  logic [sas_pkg::RES_W-1:0] vin [sas_pkg::NCH];
  logic [sas_pkg::RES_W-1:0] held;
  assign vin = '{10'h155, 10'h2AA, 10'h3FF, 10'h0C3};
  // The hold capacitor follows the selected input only while sampling.
  always @(*) begin
    if (sample_in) begin
      held = vin[chan_in];
    end
  end
  // Keep the trial bit while the held input is at or above the code.
  assign comp_out = (held >= dac_in);
endmodule : sas_analog_model

// ---- sim/sas_sequencer_tb_top.sv ----
// Self-checking bench of the converter sequencer.
`timescale 1ns/1ps
module sas_sequencer_tb_top;
  logic clk_in;
  logic nrst_in;
  sas_pkg::sas_bus_req_t bus;
  logic [15:0] rdata;
  logic trig_n;
  logic comp;
  logic sample;
  logic [1:0] chan;
  logic [9:0] dac;
  logic irq;
  int mismatches;
  int total_checks;
  int cyc;
  int t0;
  int t1;

  // Design and analog model.
  sas_sequencer i_sas_sequencer (.clk_in(clk_in), .nrst_in(nrst_in),
    .bus_in(bus), .rdata_out(rdata), .ext_trigger_pin_n_in(trig_n),
    .comp_in(comp), .sample_out(sample), .chan_out(chan), .dac_out(dac),
    .conv_end_irq_out(irq));
  sas_analog_model i_sas_analog_model (.sample_in(sample), .chan_in(chan),
    .dac_in(dac), .comp_out(comp));

  // Clock and a free cycle count used to time conversions.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  // Prints counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Compares one value with its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus.addr <= a;
    bus.wdata <= {8'h00, d};
    bus.wr <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask : wr

  // One-cycle register read; data are taken in the following cycle.
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  // Waits for the interrupt under a bound and stamps its cycle.
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      give_verdict();
    end
    t = cyc;
  endtask : wait_irq

  // Starts by a write and checks the cycles until the interrupt.
  task automatic conv(input logic [7:0] csr, input int lo, input int hi);
    wr(sas_pkg::OFS_CSR, csr);
    #1;
    t0 = cyc;
    wait_irq(t1);
    chk(16'(t1 - t0 >= lo && t1 - t0 <= hi), 16'h1);
  endtask : conv

  // Low pulse on the trigger pin, long enough for the synchroniser.
  task automatic pulse();
    @(posedge clk_in);
    trig_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    trig_n <= 1'b1;
  endtask : pulse

  // Main sequence; the interrupt rises with the end flag.
  initial begin
    nrst_in = 1'b0;
    bus = '0;
    trig_n = 1'b1;
    cyc = 0;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_chk(sas_pkg::OFS_CSR, 16'h0000);
    rd_chk(sas_pkg::OFS_AUX, 16'h0072);
    rd_chk(4'hF, 16'h0000);
    conv(8'h62, sas_pkg::TOT_MIN_S, sas_pkg::TOT_MAX_S);
    rd_chk(sas_pkg::OFS_CSR, 16'h00C2);
    wr(sas_pkg::OFS_CSR, 8'h42);
    rd_chk(4'h4, {6'h00, i_sas_analog_model.vin[2]});
    chk({15'h0, irq}, 16'h0000);
    conv(8'h6B, sas_pkg::TOT_MIN_F, sas_pkg::TOT_MAX_F);
    rd_chk(sas_pkg::OFS_CSR, 16'h00CB);
    wr(sas_pkg::OFS_CSR, 8'h4B);
    rd_chk(4'h5, {6'h00, i_sas_analog_model.vin[3]});
    conv(8'h7A, sas_pkg::TOT_MIN_F + 2 * sas_pkg::SCAN_F,
         sas_pkg::TOT_MAX_F + 2 * sas_pkg::SCAN_F);
    for (int c = 0; c < 4; c++) begin
      rd_chk(4'(2 + c), {6'h00, i_sas_analog_model.vin[c]});
    end
    rd_chk(sas_pkg::OFS_CSR, 16'h00FA);
    wr(sas_pkg::OFS_CSR, 8'h7A);
    repeat (3) @(posedge clk_in);
    #1;
    t0 = t1;
    wait_irq(t1);
    chk(16'(t1 - t0), 16'(3 * sas_pkg::SCAN_F));
    wr(sas_pkg::OFS_CSR, 8'h5A);
    repeat (200) @(posedge clk_in);
    #1;
    chk({15'h0, sample}, 16'h0000);
    rd_chk(sas_pkg::OFS_CSR, 16'h00DA);
    wr(sas_pkg::OFS_CSR, 8'h41);
    pulse();
    repeat (10) @(posedge clk_in);
    rd_chk(sas_pkg::OFS_CSR, 16'h0041);
    wr(sas_pkg::OFS_AUX, 8'h80);
    rd_chk(sas_pkg::OFS_AUX, 16'h00F2);
    pulse();
    repeat (10) @(posedge clk_in);
    rd_chk(sas_pkg::OFS_CSR, 16'h0061);
    wait_irq(t1);
    rd_chk(sas_pkg::OFS_CSR, 16'h00C1);
    rd_chk(4'h3, {6'h00, i_sas_analog_model.vin[1]});
    wr(sas_pkg::OFS_CSR, 8'h81);
    rd_chk(sas_pkg::OFS_CSR, 16'h0081);
    chk({15'h0, irq}, 16'h0000);
    give_verdict();
  end

  // Watchdog cuts a hang short well beyond the expected run.
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end
endmodule : sas_sequencer_tb_top
